// ---- logic/tpk_defs.svh ----
/*
 * Register offsets, reset values and widths of the three-port GPIO block.
 * Included by the package and the design modules; definitions only.
 */
`ifndef TPK_DEFS_SVH
`define TPK_DEFS_SVH

`define TPK_ADDR_W 8
`define TPK_PORT_W 8
`define TPK_OFF_PORT_A_DATA 8'h00
`define TPK_OFF_PORT_B_DATA 8'h01
`define TPK_OFF_PORT_C_DATA 8'h03
`define TPK_OFF_PORT_A_DIR 8'h04
`define TPK_OFF_PORT_B_DIR 8'h05
`define TPK_OFF_PORT_C_DIR 8'h06
`define TPK_DIR_RESET 8'h00
`define TPK_DATA_INIT 8'h00
`define TPK_KEYSCAN_EN_DEFAULT 8'h00

`endif

// ---- logic/tpk_pkg.sv ----
/*
 * Types shared by the three-port GPIO block.
 * Assumes tpk_defs.svh is on the include path.
 */
`include "tpk_defs.svh"

package tpk_pkg;
	// cpu side access of one cycle
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`TPK_ADDR_W-1:0] addr;
		logic [`TPK_PORT_W-1:0] wdata;
	} tpk_bus_req_t;

	// pin group of one port: drive value and enable
	typedef struct packed {
		logic [`TPK_PORT_W-1:0] out;
		logic [`TPK_PORT_W-1:0] oe;
	} tpk_pin_drv_t;

	// interrupt sensitivity option of the external request
	typedef enum logic [1:0] {
		TPK_SENS_EDGE = 2'b01,
		TPK_SENS_EDGE_LEVEL = 2'b10
	} tpk_sens_t;
endpackage

// ---- logic/tpk_port.sv ----
/*
 * One 8-bit bidirectional port: output latch, direction register,
 * pin drive and read-back mux.
 * Assumes pins are synchronous to clk; the parent decodes addresses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tpk_defs.svh"

module tpk_port #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic data_we,
	input wire logic dir_we,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [WIDTH-1:0] pin_in,
	output tpk_pkg::tpk_pin_drv_t pin_drv,
	output logic [WIDTH-1:0] data_rd,
	output logic [WIDTH-1:0] dir_rd
);
	import tpk_pkg::*;

	logic [WIDTH-1:0] latch_r;
	logic [WIDTH-1:0] latch_nxt;
	logic [WIDTH-1:0] dir_r;
	logic [WIDTH-1:0] dir_nxt;

	// elaboration check: the pin struct is fixed at the port width
	if (WIDTH != `TPK_PORT_W)
	begin : g_bad_width
		$error("tpk_port width must match the port width");
	end

	always_comb
	begin
		latch_nxt = latch_r;
		dir_nxt = dir_r;
		if (data_we)
			latch_nxt = wdata;
		if (dir_we)
			dir_nxt = wdata;
	end

	// latch has no reset, so reset leaves the data untouched
	// data survives reset
	always_ff @(posedge clk)
	begin
		latch_r <= latch_nxt;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			dir_r <= `TPK_DIR_RESET;
		else
			dir_r <= dir_nxt;
	end

	assign pin_drv = '{out: latch_r, oe: dir_r};

	assign data_rd = (dir_r & latch_r) | (~dir_r & pin_in);
	assign dir_rd = dir_r;
endmodule

`default_nettype wire

// ---- logic/tpk_gpio.sv ----
/*
 * Three-port GPIO block with keyscan interrupt on the second port.
 * Assumes a cpu bus with one-cycle read and write strobes, pins already
 * synchronous to clk, and the mask bit provided by the modulator block.
 */
// Notes on behaviour
// - a direction bit of one makes the pin an output, zero an input.
// - reset clears all direction registers and leaves data latches alone.
// - data write with direction zero fills the latch, pin stays input.
// - data write with direction one fills the latch and drives it.
// - data read with direction zero returns the pin level.
// - data read with direction one returns the output latch.
// - every direction register can be written and read back.
// - twenty-four lines as three independent eight-bit ports.
// - second-port pins with pullup enabled are extra interrupt sources.
// - those pins share the external request's chosen sensitivity.
// - third port is a full eight bits even if pins are unbonded.
// - edge mode requests on a falling edge of an enabled pin.
// - edge-level mode requests on falling edge or low level.
// - keyscan requests are ORed with the external request pin.
// - the external mask bit suppresses all external requests.
`timescale 1ns/1ps
`default_nettype none
`include "tpk_defs.svh"

module tpk_gpio #(
	parameter int WIDTH = 8,
	parameter logic [7:0] KEYSCAN_EN = `TPK_KEYSCAN_EN_DEFAULT,
	parameter tpk_pkg::tpk_sens_t SENS = tpk_pkg::TPK_SENS_EDGE
) (
	input wire logic clk,
	input wire logic nrst,
	input wire tpk_pkg::tpk_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] second_port_pins_in,
	input wire logic [7:0] third_port_pins_in,
	output tpk_pkg::tpk_pin_drv_t port_a_drv,
	output tpk_pkg::tpk_pin_drv_t second_port_pins_drv,
	output tpk_pkg::tpk_pin_drv_t third_port_pins_drv,
	output logic [7:0] keyscan_pullup_en,
	input wire logic ext_irq_n,
	input wire logic external_irq_mask_bit,
	output logic irq_req_n
);
	import tpk_pkg::*;

	logic [7:0] rd_a;
	logic [7:0] rd_b;
	logic [7:0] rd_c;
	logic [7:0] dir_a;
	logic [7:0] dir_b;
	logic [7:0] dir_c;
	logic [7:0] rdata_nxt;
	logic [7:0] rdata_r;
	logic [7:0] kpin_r;
	logic [7:0] kpin_nxt;
	logic irq_pin_r;
	logic irq_pin_nxt;
	logic req_edge;
	logic req_level;
	logic req_any;
	logic req_r;
	logic req_nxt;

	// elaboration check: the register map is byte wide
	if (WIDTH != `TPK_PORT_W)
	begin : g_bad_width
		$error("tpk_gpio supports 8-bit ports only");
	end

	tpk_port #(.WIDTH(WIDTH)) u_port_a (
		.clk(clk),
		.nrst(nrst),
		.data_we(bus_req.wr && bus_req.addr == `TPK_OFF_PORT_A_DATA),
		.dir_we(bus_req.wr && bus_req.addr == `TPK_OFF_PORT_A_DIR),
		.wdata(bus_req.wdata),
		.pin_in(port_a_in),
		.pin_drv(port_a_drv),
		.data_rd(rd_a),
		.dir_rd(dir_a)
	);

	tpk_port #(.WIDTH(WIDTH)) u_port_b (
		.clk(clk),
		.nrst(nrst),
		.data_we(bus_req.wr && bus_req.addr == `TPK_OFF_PORT_B_DATA),
		.dir_we(bus_req.wr && bus_req.addr == `TPK_OFF_PORT_B_DIR),
		.wdata(bus_req.wdata),
		.pin_in(second_port_pins_in),
		.pin_drv(second_port_pins_drv),
		.data_rd(rd_b),
		.dir_rd(dir_b)
	);

	tpk_port #(.WIDTH(WIDTH)) u_port_c (
		.clk(clk),
		.nrst(nrst),
		.data_we(bus_req.wr && bus_req.addr == `TPK_OFF_PORT_C_DATA),
		.dir_we(bus_req.wr && bus_req.addr == `TPK_OFF_PORT_C_DIR),
		.wdata(bus_req.wdata),
		.pin_in(third_port_pins_in),
		.pin_drv(third_port_pins_drv),
		.data_rd(rd_c),
		.dir_rd(dir_c)
	);

	// read mux; unmapped and reserved offsets read as zero
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (bus_req.rd)
		begin
			unique case (bus_req.addr)
				`TPK_OFF_PORT_A_DATA: rdata_nxt = rd_a;
				`TPK_OFF_PORT_B_DATA: rdata_nxt = rd_b;
				`TPK_OFF_PORT_C_DATA: rdata_nxt = rd_c;
				`TPK_OFF_PORT_A_DIR: rdata_nxt = dir_a;
				`TPK_OFF_PORT_B_DIR: rdata_nxt = dir_b;
				`TPK_OFF_PORT_C_DIR: rdata_nxt = dir_c;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata_r <= 8'h00;
		else
			rdata_r <= rdata_nxt;
	end

	assign bus_rdata = rdata_r;

	assign keyscan_pullup_en = KEYSCAN_EN;

	// previous pin levels for falling-edge detection; idle high
	always_comb
	begin
		kpin_nxt = second_port_pins_in;
		irq_pin_nxt = ext_irq_n;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			kpin_r <= 8'hFF;
			irq_pin_r <= 1'b1;
		end
		else
		begin
			kpin_r <= kpin_nxt;
			irq_pin_r <= irq_pin_nxt;
		end
	end

	assign req_edge = |(KEYSCAN_EN & kpin_r & ~second_port_pins_in)
		| (irq_pin_r & ~ext_irq_n);
	assign req_level = |(KEYSCAN_EN & ~second_port_pins_in) | ~ext_irq_n;

	always_comb
	begin
		req_any = req_edge;
		unique case (SENS)
			TPK_SENS_EDGE: req_any = req_edge;
			TPK_SENS_EDGE_LEVEL: req_any = req_edge | req_level;
			default: req_any = req_edge;
		endcase
		req_nxt = req_any & ~external_irq_mask_bit;
	end

	// registered request; in edge mode an edge shows as a one-cycle low pulse
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			req_r <= 1'b0;
		else
			req_r <= req_nxt;
	end

	assign irq_req_n = ~req_r;
endmodule

`default_nettype wire

// ---- tb/tpk_pins.sv ----
/*
 * Far-side pin model for one port of the GPIO block.
 * Assumes released lines sit at the level the bench sets on ext.
 */
`timescale 1ns/1ps
`default_nettype none
module tpk_pins (
	input wire tpk_pkg::tpk_pin_drv_t drv,
	input wire logic [7:0] ext,
	output logic [7:0] lvl
);
	// driven bits echo the latch, released bits take the outside level
	assign lvl = drv.oe & drv.out | ~drv.oe & ext;
endmodule
`default_nettype wire

// ---- tb/tpk_chk_checker.sv ----
/*
 * Port checker for tpk_gpio, bound below.
 * Assumes the default edge-only sensitivity.
 */
`timescale 1ns/1ps
`default_nettype none
module tpk_chk #(
	parameter logic [7:0] KEYSCAN_EN = 8'h00
) (
	input wire logic clk,
	input wire logic nrst,
	input wire tpk_pkg::tpk_bus_req_t bus_req,
	input wire logic [7:0] bus_rdata,
	input wire logic [7:0] second_port_pins_in,
	input wire logic [7:0] third_port_pins_in,
	input wire tpk_pkg::tpk_pin_drv_t port_a_drv,
	input wire tpk_pkg::tpk_pin_drv_t third_port_pins_drv,
	input wire logic [7:0] keyscan_pullup_en,
	input wire logic ext_irq_n,
	input wire logic external_irq_mask_bit,
	input wire logic irq_req_n
);
	import tpk_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// short aliases; cv is what a port C data read must return
	wire logic wr = bus_req.wr;
	wire logic rd = bus_req.rd;
	wire logic m = external_irq_mask_bit;
	wire logic [7:0] ad = bus_req.addr;
	wire logic [7:0] wd = bus_req.wdata;
	wire tpk_pin_drv_t c = third_port_pins_drv;
	wire logic [7:0] cv = c.oe & c.out | ~c.oe & third_port_pins_in;
	wire logic [7:0] kf = ~second_port_pins_in & keyscan_pullup_en;
	// request sources held unmasked long enough to reach the output
	sequence s_ext;
		$fell(ext_irq_n) && !m ##1 !m[*2];
	endsequence
	sequence s_key;
		|($past(second_port_pins_in) & kf) && !m ##1 !m[*2];
	endsequence
	sequence s_quiet;
		ext_irq_n && kf == 8'h00;
	endsequence
	property p_oe_rst;
		$rose(nrst) |-> (port_a_drv.oe | c.oe) == 8'h00;
	endproperty
	property p_dir;
		wr && ad == 8'h04 |=> port_a_drv.oe == $past(wd);
	endproperty
	property p_out;
		wr && ad == 8'h00 |=> port_a_drv.out == $past(wd);
	endproperty
	property p_c_rd;
		rd && ad == 8'h03 |=> bus_rdata == $past(cv);
	endproperty
	property p_mask;
		m ##1 m |=> irq_req_n;
	endproperty
	property p_ext;
		s_ext |-> !(irq_req_n && $past(irq_req_n));
	endproperty
	property p_key;
		s_key |-> !(irq_req_n && $past(irq_req_n));
	endproperty
	property p_quiet;
		s_quiet[*4] |-> irq_req_n;
	endproperty
	a_oe_rst: assert property (p_oe_rst)
		else $error("pins not inputs after reset");
	a_dir: assert property (p_dir)
		else $error("direction write not applied");
	a_out: assert property (p_out)
		else $error("latch write not applied");
	a_c_rd: assert property (p_c_rd)
		else $error("port C read value wrong");
	a_mask: assert property (p_mask)
		else $error("request while masked");
	a_ext: assert property (p_ext)
		else $error("pin request missing");
	a_key: assert property (p_key)
		else $error("keyscan request missing");
	a_quiet: assert property (p_quiet)
		else $error("request without an edge");
endmodule
bind tpk_gpio tpk_chk #(.KEYSCAN_EN(KEYSCAN_EN)) tpk_chk_inst (.*);
`default_nettype wire

// ---- tb/tb.sv ----
/*
 * Testbench for tpk_gpio: register access, pins and requests.
 * Assumes tpk_pins models the outside of every port.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tpk_pkg::*;
	logic clk = 0, nrst = 0, eirq = 1, msk = 0, irqn;
	logic [7:0] ext = 8'hFF, rdat, pa, pb, pc;
	tpk_bus_req_t req = '0;
	tpk_pin_drv_t da, db, dc;
	int fail_count = 0, n_compared = 0, cyc = 0;
	tpk_gpio #(.KEYSCAN_EN(8'hFF)) tpk_gpio_inst (.clk(clk), .nrst(nrst),
		.bus_req(req), .bus_rdata(rdat), .port_a_in(pa),
		.second_port_pins_in(pb), .third_port_pins_in(pc),
		.port_a_drv(da), .second_port_pins_drv(db),
		.third_port_pins_drv(dc), .keyscan_pullup_en(), .ext_irq_n(eirq),
		.external_irq_mask_bit(msk), .irq_req_n(irqn));
	tpk_pins tpk_pins_inst[2:0] (.drv({dc, db, da}), .ext(ext),
		.lvl({pc, pb, pa}));
	// clock and a cut-off against hangs
	initial
		forever #4 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			print_verdict;
		end
	end
	task chk(input logic [7:0] s, x);
		n_compared++;
		if (s !== x)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge clk);
		#1 req = '{1'b1, 1'b0, a, d};
		@(posedge clk);
		#1 req = '0;
	endtask
	task rd(input logic [7:0] a, x);
		@(posedge clk);
		#1 req = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		#1 req = '0;
		chk(rdat, x);
	endtask
	// apply mask and pin levels, note any request, then release the pins
	task irq(input logic m, e, input logic [7:0] p, input logic x);
		logic s;
		s = 0;
		@(posedge clk);
		#1 {msk, eirq, ext} = {m, e, p};
		repeat (4)
		begin
			@(posedge clk);
			#1 s |= !irqn;
		end
		{eirq, ext} = {1'b1, 8'hFF};
		repeat (4) @(posedge clk);
		chk({7'h00, s}, {7'h00, x});
	endtask
	task print_verdict;
		$display("compared %0d, failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// main sequence; data offsets 00 01 03, direction 04 05 06
	initial
	begin
		logic [7:0] a, r, d;
		repeat (3) @(posedge clk);
		#1 nrst = 1;
		for (int i = 0; i < 3; i++)
		begin
			a = (i == 2) ? 8'h03 : 8'(i);
			r = 8'h04 + 8'(i);
			d = 8'hA5 ^ 8'(i);
			ext = 8'h3C;
			rd(r, 8'h00);
			wr(a, d);
			rd(a, 8'h3C);
			wr(r, 8'hFF);
			rd(r, 8'hFF);
			rd(a, d);
			wr(r, 8'h0F);
			rd(a, d & 8'h0F | 8'h30);
		end
		ext = 8'hFF;
		rd(8'h02, 8'h00);
		rd(8'h07, 8'h00);
		// reset in mid-run must keep the latches
		wr(8'h01, 8'hFF);
		nrst = 0;
		repeat (2) @(posedge clk);
		#1 nrst = 1;
		rd(8'h06, 8'h00);
		wr(8'h06, 8'hFF);
		rd(8'h03, 8'hA7);
		irq(0, 1, 8'hFE, 1);
		irq(0, 0, 8'hFF, 1);
		irq(1, 0, 8'h7F, 0);
		irq(0, 1, 8'hFF, 0);
		print_verdict;
	end
endmodule
`default_nettype wire
